// File: npid_defs.svh
/*
 * Named constants of the protection and identification block: register offsets,
 * field positions, field masks and the default memory map.
 * Assumes it is included by its bare name from every file that needs it.
 */
`ifndef NPID_DEFS_SVH
`define NPID_DEFS_SVH

// Address width and register offsets.
`define NPID_AW          22
`define NPID_DW          16
`define NPID_ADDR_WP     22'h300006
`define NPID_ADDR_CP     22'h300008
`define NPID_ADDR_TRP    22'h30000A
`define NPID_ADDR_STAT   22'h300010
`define NPID_ADDR_REV    22'h3FFFFC
`define NPID_ADDR_PART   22'h3FFFFE

// Memory map used by the region decoder.
`define NPID_BOOT_LAST   22'h0007FF
`define NPID_USER_LAST   22'h007FFF
`define NPID_BLK_SHIFT   13
`define NPID_CFG_FIRST   22'h300000
`define NPID_CFG_LAST    22'h30000B

// Field positions inside the protection words and the status word.
`define NPID_WP_CFG      8
`define NPID_WP_BOOT     9
`define NPID_WP_DATA     10
`define NPID_CP_PROG     0
`define NPID_CP_DATA     1
`define NPID_TRP_BOOT    9
`define NPID_STAT_LOADED 0
`define NPID_STAT_REFUSE 1

// Implemented bits of each word; all others read as zero.
`define NPID_WP_MASK     16'h070F
`define NPID_CP_MASK     16'h0003
`define NPID_TRP_MASK    16'h020F
`define NPID_ZERO        16'h0000

`endif

// File: npid_pkg.sv
/*
 * Types shared by the protection and identification block.
 * Assumes npid_defs.svh is available on the include path.
 */
`default_nettype none

package npid_pkg;

	// Memory region that an address falls in.
	typedef enum logic [1:0] {NPID_RG_BOOT, NPID_RG_USER, NPID_RG_CFG, NPID_RG_NONE} npid_region_t;

	// Steps of the reset-time load of the protection words.
	typedef enum logic [2:0] {NPID_LD_WP, NPID_LD_CP, NPID_LD_TRP, NPID_LD_LAST, NPID_LD_DONE} npid_ld_state_t;

endpackage

`default_nettype wire

// File: npid_region_decode.sv
/*
 * Combinational decoder from a program memory address to a region and block index.
 * Assumes the boot block sits at the bottom and the numbered blocks share one size.
 */
`timescale 1ns/1ps
`default_nettype none
`include "npid_defs.svh"

module npid_region_decode #(
	parameter int                AW        = `NPID_AW,
	parameter logic [AW-1:0]     BOOT_LAST = `NPID_BOOT_LAST,
	parameter logic [AW-1:0]     USER_LAST = `NPID_USER_LAST,
	parameter int                BLK_SHIFT = `NPID_BLK_SHIFT
) (
	input  wire logic [AW-1:0]   addr,
	output npid_pkg::npid_region_t region,
	output logic [1:0]           blk
);

	// Region selection; the block index only matters in the user region.
	wire in_boot = (addr <= BOOT_LAST);
	wire in_user = (addr <= USER_LAST);
	wire in_cfg  = (addr >= `NPID_CFG_FIRST) && (addr <= `NPID_CFG_LAST);

	assign blk    = addr[BLK_SHIFT +: 2];
	assign region = in_boot ? npid_pkg::NPID_RG_BOOT :
	                in_user ? npid_pkg::NPID_RG_USER :
	                in_cfg  ? npid_pkg::NPID_RG_CFG  : npid_pkg::NPID_RG_NONE;

endmodule

`default_nettype wire

// File: npid_cfg_loader.sv
/*
 * Reset-time loader: reads the three protection words from configuration memory
 * and holds them until the next reset.
 * Assumes the memory answers a read one cycle after the read enable, on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "npid_defs.svh"

module npid_cfg_loader (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	output logic             cfg_rd_en,
	output logic [21:0]      cfg_rd_addr,
	input  wire logic [15:0] cfg_rd_data,
	output logic [15:0]      wp,
	output logic [15:0]      cp,
	output logic [15:0]      trp,
	output logic             loaded
);

	npid_pkg::npid_ld_state_t state;
	npid_pkg::npid_ld_state_t next_state;

	// Read requests are issued one word per cycle straight after reset.
	assign cfg_rd_en   = (state == npid_pkg::NPID_LD_WP) || (state == npid_pkg::NPID_LD_CP) ||
	                     (state == npid_pkg::NPID_LD_TRP);
	assign cfg_rd_addr = (state == npid_pkg::NPID_LD_WP) ? `NPID_ADDR_WP :
	                     (state == npid_pkg::NPID_LD_CP) ? `NPID_ADDR_CP : `NPID_ADDR_TRP;
	assign loaded      = (state == npid_pkg::NPID_LD_DONE);

	// Step through the load once and then stay put.
	always_comb begin
		unique case (state)
			npid_pkg::NPID_LD_WP:   next_state = npid_pkg::NPID_LD_CP;
			npid_pkg::NPID_LD_CP:   next_state = npid_pkg::NPID_LD_TRP;
			npid_pkg::NPID_LD_TRP:  next_state = npid_pkg::NPID_LD_LAST;
			npid_pkg::NPID_LD_LAST: next_state = npid_pkg::NPID_LD_DONE;
			npid_pkg::NPID_LD_DONE: next_state = npid_pkg::NPID_LD_DONE;
			default:                next_state = npid_pkg::NPID_LD_WP;
		endcase
	end

	// Fields reset to all-protected so nothing is allowed before the load ends.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= npid_pkg::NPID_LD_WP;
			wp    <= `NPID_ZERO;
			cp    <= `NPID_ZERO;
			trp   <= `NPID_ZERO;
		end else begin
			state <= next_state;
			if (state == npid_pkg::NPID_LD_CP) wp <= cfg_rd_data & `NPID_WP_MASK;
			if (state == npid_pkg::NPID_LD_TRP) cp <= cfg_rd_data & `NPID_CP_MASK;
			if (state == npid_pkg::NPID_LD_LAST) trp <= cfg_rd_data & `NPID_TRP_MASK;
		end
	end

endmodule

`default_nettype wire

// File: npid_protect.sv
/*
 * Top of the protection and identification block: register port, access guard
 * for program memory, boot block, data memory and configuration area, and the
 * read-only identification words.
 * Assumes configuration memory answers reads one cycle later on ref_clk, and
 * that at most one access request input is high in any cycle.
 */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "npid_defs.svh"

module npid_protect #(
	parameter logic [15:0] PART_CODE   = 16'h1234, // Arbitrary value.
	parameter logic [3:0]  FAMILY_CODE = 4'h5,     // Arbitrary value.
	parameter logic [5:0]  MAJOR_REV   = 6'h01,    // Arbitrary value.
	parameter logic [5:0]  MINOR_REV   = 6'h02     // Arbitrary value.
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [21:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	output logic             cfg_rd_en,
	output logic [21:0]      cfg_rd_addr,
	input  wire logic [15:0] cfg_rd_data,
	output logic             prog_en,
	output logic [21:0]      prog_addr,
	output logic [15:0]      prog_data,
	input  wire logic [21:0] acc_addr,
	input  wire logic [21:0] acc_src_addr,
	input  wire logic        acc_data_mem,
	input  wire logic        acc_self_write,
	input  wire logic        acc_table_read,
	input  wire logic        acc_ext_read,
	output logic             acc_allow
);

	logic [15:0]            wp;
	logic [15:0]            cp;
	logic [15:0]            trp;
	logic                   loaded;
	logic                   refused;
	npid_pkg::npid_region_t tgt_region;
	npid_pkg::npid_region_t src_region;
	logic [1:0]             tgt_blk;
	logic [1:0]             src_blk;

	// Protection words come in from configuration memory once per reset.
	npid_cfg_loader u_loader (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.cfg_rd_en   (cfg_rd_en),
		.cfg_rd_addr (cfg_rd_addr),
		.cfg_rd_data (cfg_rd_data),
		.wp          (wp),
		.cp          (cp),
		.trp         (trp),
		.loaded      (loaded)
	);

	// The target and the executing code are decoded by the same map.
	npid_region_decode u_tgt_dec (
		.addr   (acc_addr),
		.region (tgt_region),
		.blk    (tgt_blk)
	);

	npid_region_decode u_src_dec (
		.addr   (acc_src_addr),
		.region (src_region),
		.blk    (src_blk)
	);

	// Self-write permission per target region.
	wire [3:0] blk_wr_open  = wp[3:0];
	wire       boot_wr_open = wp[`NPID_WP_BOOT];
	wire       cfg_wr_open  = wp[`NPID_WP_CFG];
	wire       data_wr_open = wp[`NPID_WP_DATA];
	wire       pm_wr_open   = (tgt_region == npid_pkg::NPID_RG_BOOT) ? boot_wr_open :
	                          (tgt_region == npid_pkg::NPID_RG_USER) ? blk_wr_open[tgt_blk] :
	                          (tgt_region == npid_pkg::NPID_RG_CFG)  ? cfg_wr_open : 1'b0;
	wire       wr_ok        = acc_data_mem ? data_wr_open : pm_wr_open;

	// Table reads are checked only when code reads outside its own block.
	wire [3:0] blk_rd_open  = trp[3:0];
	wire       same_block   = (src_region == tgt_region) &&
	                          ((tgt_region != npid_pkg::NPID_RG_USER) || (src_blk == tgt_blk));
	wire       tr_guard     = (tgt_region == npid_pkg::NPID_RG_BOOT) ? trp[`NPID_TRP_BOOT] :
	                          (tgt_region == npid_pkg::NPID_RG_USER) ? blk_rd_open[tgt_blk] :
	                          (tgt_region == npid_pkg::NPID_RG_CFG);
	wire       tr_ok        = acc_data_mem || same_block || tr_guard;

	// Outside reads obey code protection; the configuration area stays readable.
	wire       pm_code_open = (tgt_region == npid_pkg::NPID_RG_CFG) ||
	                          (((tgt_region == npid_pkg::NPID_RG_BOOT) ||
	                            (tgt_region == npid_pkg::NPID_RG_USER)) && cp[`NPID_CP_PROG]);
	wire       ext_ok       = acc_data_mem ? cp[`NPID_CP_DATA] : pm_code_open;

	// Nothing is allowed until the fields are loaded.
	assign acc_allow = loaded && ((acc_self_write && wr_ok) || (acc_table_read && tr_ok) ||
	                              (acc_ext_read && ext_ok));

	// Register port decode; writes go to configuration memory only while unlocked.
	wire        hit_cfg_wr = reg_wr && ((reg_addr == `NPID_ADDR_WP) || (reg_addr == `NPID_ADDR_TRP));
	wire        wr_granted = hit_cfg_wr && loaded && cfg_wr_open;
	wire        wr_refused = hit_cfg_wr && !wr_granted;
	wire        stat_clr   = reg_wr && (reg_addr == `NPID_ADDR_STAT) && reg_wdata[`NPID_STAT_REFUSE];
	wire        next_refused = wr_refused || (refused && !stat_clr);
	wire [15:0] rev_word   = {FAMILY_CODE, MAJOR_REV, MINOR_REV};
	wire [15:0] stat_word  = {14'h0000, refused, loaded};
	wire [15:0] rd_val     = (reg_addr == `NPID_ADDR_WP)   ? wp :
	                         (reg_addr == `NPID_ADDR_CP)   ? cp :
	                         (reg_addr == `NPID_ADDR_TRP)  ? trp :
	                         (reg_addr == `NPID_ADDR_STAT) ? stat_word :
	                         (reg_addr == `NPID_ADDR_REV)  ? rev_word :
	                         (reg_addr == `NPID_ADDR_PART) ? PART_CODE : `NPID_ZERO;
	wire [15:0] next_rdata = reg_rd ? rd_val : `NPID_ZERO;

	// Read data for one cycle, the programming request and the refused flag.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `NPID_ZERO;
			prog_en   <= 1'b0;
			prog_addr <= 22'h000000;
			prog_data <= `NPID_ZERO;
			refused   <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			prog_en   <= wr_granted;
			prog_addr <= reg_addr;
			prog_data <= reg_wdata;
			refused   <= next_refused;
		end
	end

	// Checks on the logic above.
	property p_cfg_lock;
		@(posedge ref_clk) disable iff (rst)
		(hit_cfg_wr && !wp[`NPID_WP_CFG]) |=> (!prog_en && refused);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("locked config write went out");

	property p_cfg_open;
		@(posedge ref_clk) disable iff (rst)
		(hit_cfg_wr && loaded && wp[`NPID_WP_CFG]) |=> (prog_en && (prog_data == $past(reg_wdata)));
	endproperty
	a_cfg_open: assert property (p_cfg_open) else $error("unlocked config write lost");

	property p_blk_wr;
		@(posedge ref_clk) disable iff (rst)
		(acc_self_write && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_USER))
		|-> (acc_allow == (loaded && wp[tgt_blk]));
	endproperty
	a_blk_wr: assert property (p_blk_wr) else $error("block self-write guard wrong");

	property p_data_cp;
		@(posedge ref_clk) disable iff (rst)
		(acc_ext_read && acc_data_mem) |-> (acc_allow == (loaded && cp[`NPID_CP_DATA]));
	endproperty
	a_data_cp: assert property (p_data_cp) else $error("data code guard wrong");

	property p_prog_cp;
		@(posedge ref_clk) disable iff (rst)
		(acc_ext_read && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_USER) && !cp[`NPID_CP_PROG])
		|-> !acc_allow;
	endproperty
	a_prog_cp: assert property (p_prog_cp) else $error("program code guard wrong");

	property p_boot_tr;
		@(posedge ref_clk) disable iff (rst)
		(acc_table_read && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_BOOT) &&
		 (src_region != npid_pkg::NPID_RG_BOOT)) |-> (acc_allow == (loaded && trp[`NPID_TRP_BOOT]));
	endproperty
	a_boot_tr: assert property (p_boot_tr) else $error("boot table read guard wrong");

	property p_blk_tr;
		@(posedge ref_clk) disable iff (rst)
		(acc_table_read && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_USER) &&
		 ((src_region != npid_pkg::NPID_RG_USER) || (src_blk != tgt_blk)) && !trp[tgt_blk]) |-> !acc_allow;
	endproperty
	a_blk_tr: assert property (p_blk_tr) else $error("block table read guard wrong");

	property p_part_id;
		@(posedge ref_clk) disable iff (rst)
		(reg_rd && (reg_addr == `NPID_ADDR_PART)) |=> (reg_rdata == PART_CODE);
	endproperty
	a_part_id: assert property (p_part_id) else $error("part word wrong");

	property p_family;
		@(posedge ref_clk) disable iff (rst)
		(reg_rd && (reg_addr == `NPID_ADDR_REV)) |=> (reg_rdata[15:12] == FAMILY_CODE);
	endproperty
	a_family: assert property (p_family) else $error("family code wrong");

	property p_major;
		@(posedge ref_clk) disable iff (rst)
		(reg_rd && (reg_addr == `NPID_ADDR_REV)) |=> (reg_rdata[11:6] == MAJOR_REV);
	endproperty
	a_major: assert property (p_major) else $error("major revision wrong");

	property p_minor;
		@(posedge ref_clk) disable iff (rst)
		(reg_rd && (reg_addr == `NPID_ADDR_REV)) |=> ((reg_rdata[5:0] == MINOR_REV) && !prog_en);
	endproperty
	a_minor: assert property (p_minor) else $error("minor revision wrong");

	property p_boot_wr;
		@(posedge ref_clk) disable iff (rst)
		(acc_self_write && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_BOOT))
		|-> (acc_allow == (loaded && wp[`NPID_WP_BOOT]));
	endproperty
	a_boot_wr: assert property (p_boot_wr) else $error("boot write guard wrong");

	property p_data_wr;
		@(posedge ref_clk) disable iff (rst)
		(acc_self_write && acc_data_mem && !wp[`NPID_WP_DATA]) |-> !acc_allow;
	endproperty
	a_data_wr: assert property (p_data_wr) else $error("data write guard wrong");

	property p_decode;
		@(posedge ref_clk) disable iff (rst)
		(acc_addr <= `NPID_BOOT_LAST) |-> (tgt_region == npid_pkg::NPID_RG_BOOT);
	endproperty
	a_decode: assert property (p_decode) else $error("boot decode wrong");

	property p_hold;
		@(posedge ref_clk) disable iff (rst)
		(loaded && $past(loaded)) |-> ($stable(wp) && $stable(cp) && $stable(trp));
	endproperty
	a_hold: assert property (p_hold) else $error("fields moved after load");

	property p_load_time;
		@(posedge ref_clk) disable iff (rst)
		(cfg_rd_en && (cfg_rd_addr == `NPID_ADDR_WP)) |-> (cfg_rd_en [*3] ##1 !cfg_rd_en ##1 loaded);
	endproperty
	a_load_time: assert property (p_load_time) else $error("load sequence wrong");

	property p_refuse_set_wins;
		@(posedge ref_clk) disable iff (rst)
		(wr_refused || (refused && !stat_clr)) |=> refused;
	endproperty
	a_refuse_set_wins: assert property (p_refuse_set_wins) else $error("refused flag lost");

	property p_cfg_self_wr;
		@(posedge ref_clk) disable iff (rst)
		(acc_self_write && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_CFG))
		|-> (acc_allow == (loaded && wp[`NPID_WP_CFG]));
	endproperty
	a_cfg_self_wr: assert property (p_cfg_self_wr) else $error("config area write guard wrong");

	property p_boot_cp;
		@(posedge ref_clk) disable iff (rst)
		(acc_ext_read && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_BOOT) && !cp[`NPID_CP_PROG])
		|-> !acc_allow;
	endproperty
	a_boot_cp: assert property (p_boot_cp) else $error("boot code guard wrong");

	property p_blk_own_tr;
		@(posedge ref_clk) disable iff (rst)
		(acc_table_read && !acc_data_mem && (tgt_region == npid_pkg::NPID_RG_USER) &&
		 (src_region == npid_pkg::NPID_RG_USER) && (src_blk == tgt_blk)) |-> (acc_allow == loaded);
	endproperty
	a_blk_own_tr: assert property (p_blk_own_tr) else $error("own block table read refused");

	property p_blk_map;
		@(posedge ref_clk) disable iff (rst)
		((acc_addr > `NPID_BOOT_LAST) && (acc_addr <= `NPID_USER_LAST))
		|-> ((tgt_region == npid_pkg::NPID_RG_USER) && (tgt_blk == acc_addr[`NPID_BLK_SHIFT +: 2]));
	endproperty
	a_blk_map: assert property (p_blk_map) else $error("block decode wrong");

	property p_part_ro;
		@(posedge ref_clk) disable iff (rst)
		(reg_wr && (reg_addr == `NPID_ADDR_PART)) |=> !prog_en;
	endproperty
	a_part_ro: assert property (p_part_ro) else $error("part word write went out");

	property p_rev_ro;
		@(posedge ref_clk) disable iff (rst)
		(reg_wr && (reg_addr == `NPID_ADDR_REV)) |=> !prog_en;
	endproperty
	a_rev_ro: assert property (p_rev_ro) else $error("revision word write went out");

	property p_early;
		@(posedge ref_clk) disable iff (rst)
		!loaded |-> !acc_allow;
	endproperty
	a_early: assert property (p_early) else $error("access allowed before load");

	property p_rd_idle;
		@(posedge ref_clk) disable iff (rst)
		!reg_rd |=> (reg_rdata == `NPID_ZERO);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

endmodule

`default_nettype wire

// File: npid_protect_test.sv
/*
 * Self-checking bench for npid_protect: it loads the protection words from a configuration memory
 * stand-in, then exercises the register port and the access guard across several resets.
 * Assumes npid_defs.svh and npid_pkg are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "npid_defs.svh"

module npid_protect_test;
	typedef struct packed {logic g; logic [21:0] a; logic [15:0] d;} npid_wr_t;
	localparam logic [15:0] PART = 16'h4B2D; // Arbitrary value.
	localparam logic [3:0]  FAM  = 4'h6;     // Arbitrary value.
	localparam logic [5:0]  MAJ  = 6'h15;    // Arbitrary value.
	localparam logic [5:0]  MIN  = 6'h2A;    // Arbitrary value.
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [21:0] reg_addr = 22'h000000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        cfg_rd_en;
	logic [21:0] cfg_rd_addr;
	logic [15:0] cfg_rd_data = 16'h0000;
	logic        prog_en;
	logic [21:0] prog_addr;
	logic [15:0] prog_data;
	logic [21:0] acc_addr = 22'h000000;
	logic [21:0] acc_src_addr = 22'h000000;
	logic        acc_data_mem = 1'b0;
	logic        acc_self_write = 1'b0;
	logic        acc_table_read = 1'b0;
	logic        acc_ext_read = 1'b0;
	logic        acc_allow;
	int          failures = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [15:0] cfg_w [3];
	logic [15:0] wp_m, cp_m, trp_m, e16;
	logic        loaded_m, ref_m, rd_seen, wr_seen, g;
	npid_wr_t    w;
	logic [15:0] rd_q [$];
	logic        acc_q [$];
	npid_wr_t    wr_q [$];

	npid_protect #(.PART_CODE(PART), .FAMILY_CODE(FAM), .MAJOR_REV(MAJ), .MINOR_REV(MIN)) npid_protect_inst (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_rd_en(cfg_rd_en), .cfg_rd_addr(cfg_rd_addr),
		.cfg_rd_data(cfg_rd_data), .prog_en(prog_en), .prog_addr(prog_addr), .prog_data(prog_data),
		.acc_addr(acc_addr), .acc_src_addr(acc_src_addr), .acc_data_mem(acc_data_mem),
		.acc_self_write(acc_self_write), .acc_table_read(acc_table_read), .acc_ext_read(acc_ext_read),
		.acc_allow(acc_allow));

	// The clock toggles every 4 ns, half of its 8 ns period.
	always #4 ref_clk = ~ref_clk;

	// Configuration memory answers one cycle after the enable; otherwise the data line keeps changing.
	always @(posedge ref_clk) begin
		case (cfg_rd_addr)
			`NPID_ADDR_WP:  cfg_rd_data <= cfg_rd_en ? cfg_w[0] : ~cfg_rd_data;
			`NPID_ADDR_CP:  cfg_rd_data <= cfg_rd_en ? cfg_w[1] : ~cfg_rd_data;
			`NPID_ADDR_TRP: cfg_rd_data <= cfg_rd_en ? cfg_w[2] : ~cfg_rd_data;
			default:        cfg_rd_data <= ~cfg_rd_data;
		endcase
	end

	// Compares a seen value with the expected one and counts the outcome.
	task automatic check(input string nm, input logic [21:0] seen, input logic [21:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic complete_run();
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// A hung run is cut short and counted as a mismatch.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			complete_run();
		end
	end

	// Watches the outputs and takes the oldest expectation whenever a result is due.
	always @(posedge ref_clk) begin
		if (rd_seen && rd_q.size() > 0) begin
			e16 = rd_q.pop_front();
			check("reg_rdata", reg_rdata, e16);
		end else if (!rst) begin
			check("reg_rdata idle", reg_rdata, 16'h0000);
		end
		if (wr_seen && wr_q.size() > 0) begin
			w = wr_q.pop_front();
			check("prog_en", prog_en, w.g);
			if (w.g) begin
				check("prog_addr", prog_addr, w.a);
				check("prog_data", prog_data, w.d);
			end
		end else if (!rst) begin
			check("prog_en idle", prog_en, 1'b0);
		end
		if ((acc_self_write | acc_table_read | acc_ext_read) && acc_q.size() > 0) begin
			g = acc_q.pop_front();
			check("acc_allow", acc_allow, g);
		end
		rd_seen <= reg_rd & ~rst;
		wr_seen <= reg_wr & ~rst;
	end

	// Region of an address: 0 boot, 1 numbered block, 2 configuration area, 3 none.
	function automatic logic [1:0] rg(input logic [21:0] a);
		if (a <= 22'h0007FF) return 2'd0;
		if (a <= 22'h007FFF) return 2'd1;
		if (a >= 22'h300000 && a <= 22'h30000B) return 2'd2;
		return 2'd3;
	endfunction

	// Expected guard answer for a request of kind k from the loaded fields.
	function automatic logic exp_allow(input int k, input logic [21:0] a, input logic [21:0] s, input logic dm);
		logic [1:0] rt;
		logic [1:0] rs;
		rt = rg(a);
		rs = rg(s);
		if (!loaded_m) return 1'b0;
		if (k == 0) return dm ? wp_m[10] : rt == 0 ? wp_m[9] : rt == 1 ? wp_m[a[14:13]] : rt == 2 ? wp_m[8] : 1'b0;
		if (k == 1) begin
			if (dm || (rt == rs && (rt != 1 || a[14:13] == s[14:13]))) return 1'b1;
			return rt == 0 ? trp_m[9] : rt == 1 ? trp_m[a[14:13]] : rt == 2;
		end
		return dm ? cp_m[1] : rt <= 1 ? cp_m[0] : rt == 2;
	endfunction

	// Picks an address inside the region r.
	function automatic logic [21:0] pick(input int r);
		case (r)
			0:       return 22'($urandom_range(0, 32'h7FF));
			1:       return 22'($urandom_range(32'h800, 32'h7FFF));
			2:       return 22'h300000 + 22'($urandom_range(0, 11));
			default: return 22'h100000;
		endcase
	endfunction

	// One-cycle register write with its expected forwarding.
	task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic gr);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		wr_q.push_back({gr, a, d});
	endtask

	// One-cycle register read with its expected data.
	task automatic rd(input logic [21:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		rd_q.push_back(e);
	endtask

	// Releases both strobes.
	task automatic idle();
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
	endtask

	// Presents one access request and notes the expected answer.
	task automatic acc(input int k, input logic [21:0] a, input logic [21:0] s, input logic dm);
		@(posedge ref_clk);
		acc_addr <= a;
		acc_src_addr <= s;
		acc_data_mem <= dm;
		acc_self_write <= (k == 0);
		acc_table_read <= (k == 1);
		acc_ext_read <= (k == 2);
		acc_q.push_back(exp_allow(k, a, s, dm));
	endtask

	// Main sequence: several loads with different protection words.
	initial begin
		void'($urandom(32'hC84A));
		for (int it = 0; it < 6; it++) begin
			cfg_w[0] = (it == 0) ? 16'h0000 : (it == 1) ? 16'hFFFF : 16'($urandom);
			cfg_w[1] = (it == 0) ? 16'h0000 : (it == 1) ? 16'hFFFF : 16'($urandom);
			cfg_w[2] = (it == 0) ? 16'h0000 : (it == 1) ? 16'hFFFF : 16'($urandom);
			@(posedge ref_clk);
			rst <= 1'b1;
			repeat (3) @(posedge ref_clk);
			rst <= 1'b0;
			loaded_m = 1'b0;
			ref_m = 1'b1;
			// The loader asks for the write protection word first, mid-cycle after release.
			@(negedge ref_clk);
			check("cfg_rd_en", cfg_rd_en, 1'b1);
			check("cfg_rd_addr", cfg_rd_addr, `NPID_ADDR_WP);
			wr(`NPID_ADDR_WP, 16'h0F0F, 1'b0);
			idle();
			acc(0, 22'h000800, 22'h000000, 1'b0);
			@(posedge ref_clk);
			{acc_self_write, acc_table_read, acc_ext_read} <= 3'b000;
			repeat (6) @(posedge ref_clk);
			loaded_m = 1'b1;
			wp_m = cfg_w[0] & `NPID_WP_MASK;
			cp_m = cfg_w[1] & `NPID_CP_MASK;
			trp_m = cfg_w[2] & `NPID_TRP_MASK;
			rd(`NPID_ADDR_WP, wp_m);
			rd(`NPID_ADDR_CP, cp_m);
			rd(`NPID_ADDR_TRP, trp_m);
			rd(`NPID_ADDR_REV, {FAM, MAJ, MIN});
			rd(`NPID_ADDR_PART, PART);
			rd(`NPID_ADDR_STAT, {14'h0000, ref_m, 1'b1});
			rd(22'h200000, 16'h0000);
			wr(`NPID_ADDR_CP, 16'($urandom), 1'b0);
			wr(`NPID_ADDR_REV, 16'hFFFF, 1'b0);
			wr(`NPID_ADDR_PART, 16'h0000, 1'b0);
			rd(`NPID_ADDR_REV, {FAM, MAJ, MIN});
			rd(`NPID_ADDR_PART, PART);
			wr(`NPID_ADDR_STAT, 16'h0002, 1'b0);
			ref_m = 1'b0;
			wr(`NPID_ADDR_WP, 16'($urandom), wp_m[8]);
			wr(`NPID_ADDR_TRP, 16'($urandom), wp_m[8]);
			ref_m = ~wp_m[8];
			rd(`NPID_ADDR_WP, wp_m);
			rd(`NPID_ADDR_TRP, trp_m);
			rd(`NPID_ADDR_STAT, {14'h0000, ref_m, 1'b1});
			idle();
			for (int n = 0; n < 60; n++) begin
				acc(n % 3, pick($urandom_range(0, 3)), pick($urandom_range(0, 2)), ($urandom_range(0, 7) == 0));
			end
			@(posedge ref_clk);
			{acc_self_write, acc_table_read, acc_ext_read} <= 3'b000;
			repeat (3) @(posedge ref_clk);
		end
		complete_run();
	end
endmodule
`default_nettype wire
